// >>> asi_slot_map.sv
/*
  Slot map for audio channels six to eight: Avalon-MM register slave on the system clock,
  word handshake into the bit-clock domain, frame counter and serial drivers on two lines.
  Assumes the host supplies the bit clock and frame sync, both aligned to the bit clock,
  and that the sample source presents one word per channel with a one-cycle valid strobe.
*/
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module asi_slot_map
(
  // Clock and reset
  input  wire logic                                 REF_CLK_I,
  input  wire logic                                 RESETN_I,
  // Avalon-MM register slave
  input  wire logic [asi_slot_pkg::ADDR_W-1:0]      AVS_ADDRESS_I,
  input  wire logic                                 AVS_READ_I,
  input  wire logic                                 AVS_WRITE_I,
  input  wire logic [asi_slot_pkg::DATA_W-1:0]      AVS_WRITEDATA_I,
  input  wire logic [3:0]                           AVS_BYTEENABLE_I,
  output logic      [asi_slot_pkg::DATA_W-1:0]      AVS_READDATA_O,
  output logic                                      AVS_WAITREQUEST_O,
  // Sample words from the converter
  input  wire asi_slot_pkg::sample_set_type         SAMPLE_DATA_I,
  input  wire logic                                 SAMPLE_VALID_I,
  // Serial link
  input  wire logic                                 BIT_CLK_I,
  input  wire logic                                 FRAME_SYNC_I,
  output logic                                      PRIMARY_SERIAL_OUT_O,
  output logic                                      PRIMARY_SERIAL_OUT_OE_O,
  output logic                                      SECONDARY_OUT_PIN_A_O,
  output logic                                      SECONDARY_OUT_PIN_A_OE_O
);
  import asi_slot_pkg::*;

  // ----------------------------------------------------------------
  // Reset synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta;
  logic       rst_n;
  logic       lrst_meta;
  logic       lrst_n;

  // System reset: asserted at once, released after two edges
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Link reset: released only while the bit clock runs
  always_ff @(posedge BIT_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      lrst_meta <= 1'b0;
      lrst_n    <= 1'b0;
    end
    else
    begin
      lrst_meta <= 1'b1;
      lrst_n    <= lrst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Register slave (system clock)
  // ----------------------------------------------------------------
  chan_cfg_type [CHANS-1:0] cfg;
  logic                     half_mode;
  logic                     bus_ack;
  logic                     wr_commit;
  logic                     rd_take;
  logic [IDX_W-1:0]         bus_idx;
  logic [DATA_W-1:0]        next_readdata;
  logic                     link_active;
  xfer_state_type           xfer_state;

  assign bus_idx           = AVS_ADDRESS_I[ADDR_W-1:IDX_LSB];
  // One wait cycle per access, so read data can come from a flop
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !bus_ack;
  assign wr_commit         = AVS_WRITE_I && bus_ack && AVS_BYTEENABLE_I[0];
  assign rd_take           = AVS_READ_I && !bus_ack;

  // Acknowledge pulses high for one cycle per request
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      bus_ack <= 1'b0;
    else
      bus_ack <= (AVS_READ_I || AVS_WRITE_I) && !bus_ack;
  end

  // Channel slot registers; reserved bit is never stored
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg[0] <= '{line_sel: LINE_PRIMARY, slot_index: SLOT6_RESET};
      cfg[1] <= '{line_sel: LINE_PRIMARY, slot_index: SLOT7_RESET};
      cfg[2] <= '{line_sel: LINE_PRIMARY, slot_index: SLOT8_RESET};
    end
    else if (wr_commit)
    begin
      case (bus_idx)
        IDX_CH6: cfg[0] <= chan_cfg_type'(AVS_WRITEDATA_I[LINE_BIT:0]);
        IDX_CH7: cfg[1] <= chan_cfg_type'(AVS_WRITEDATA_I[LINE_BIT:0]);
        IDX_CH8: cfg[2] <= chan_cfg_type'(AVS_WRITEDATA_I[LINE_BIT:0]);
        default: ;
      endcase
    end
  end

  // Frame format: TDM or half-frame (I2S / left-justified)
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      half_mode <= 1'b0;
    else if (wr_commit && bus_idx == IDX_FORMAT)
      half_mode <= AVS_WRITEDATA_I[FMT_HALF_BIT];
  end

  // Read mux; unmapped words read as zero
  always_comb
  begin
    next_readdata = '0;
    case (bus_idx)
      IDX_CH6:    next_readdata[LINE_BIT:0] = cfg[0];
      IDX_CH7:    next_readdata[LINE_BIT:0] = cfg[1];
      IDX_CH8:    next_readdata[LINE_BIT:0] = cfg[2];
      IDX_FORMAT: next_readdata[FMT_HALF_BIT] = half_mode;
      IDX_STATUS:
      begin
        next_readdata[STS_LINK_BIT] = link_active;
        next_readdata[STS_BUSY_BIT] = (xfer_state != XFER_IDLE);
      end
      default:    next_readdata = '0;
    endcase
    next_readdata[RSVD_BIT] = RSVD_VALUE;
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      AVS_READDATA_O <= '0;
    else if (rd_take)
      AVS_READDATA_O <= next_readdata;
  end

  // ----------------------------------------------------------------
  // Sample capture and word handshake toward the link
  // ----------------------------------------------------------------
  sample_set_type samples;
  bundle_type     bundle;
  logic           dirty;
  logic           req_tgl;
  logic [2:0]     ack_sync;
  logic [2:0]     link_sync;
  logic           cfg_wr;
  logic           ack_tgl;    // Link-domain flop, read here only through ack_sync
  logic           link_seen;  // Link-domain flop, read here only through link_sync

  assign cfg_wr = wr_commit && (bus_idx == IDX_CH6 || bus_idx == IDX_CH7 ||
                                bus_idx == IDX_CH8 || bus_idx == IDX_FORMAT);

  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      samples <= '0;
    else if (SAMPLE_VALID_I)
      samples <= SAMPLE_DATA_I;
  end

  // New setting or sample pending; a new event beats the clear
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      dirty <= 1'b1;
    else if (cfg_wr || SAMPLE_VALID_I)
      dirty <= 1'b1;
    else if (xfer_state == XFER_LOAD)
      dirty <= 1'b0;
  end

  // Ack toggle from the link: three stages, change taken when the last two agree
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_sync  <= '0;
      link_sync <= '0;
    end
    else
    begin
      ack_sync  <= {ack_sync[1:0], ack_tgl};
      link_sync <= {link_sync[1:0], link_seen};
    end
  end

  // Link status level, taken only once stages two and three agree
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      link_active <= 1'b0;
    else if (link_sync[1] == link_sync[2])
      link_active <= link_sync[2];
  end

  // Bundle held steady from load until the link acknowledges
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xfer_state <= XFER_IDLE;
      req_tgl    <= 1'b0;
      bundle     <= '{half_mode: 1'b0,
                      cfg: {chan_cfg_type'({LINE_PRIMARY, SLOT8_RESET}),
                            chan_cfg_type'({LINE_PRIMARY, SLOT7_RESET}),
                            chan_cfg_type'({LINE_PRIMARY, SLOT6_RESET})},
                      samples: '0};
    end
    else
    begin
      case (xfer_state)
        XFER_IDLE:
          if (dirty)
            xfer_state <= XFER_LOAD;
        XFER_LOAD:
        begin
          bundle     <= '{half_mode: half_mode, cfg: cfg, samples: samples};
          req_tgl    <= !req_tgl;
          xfer_state <= XFER_WAIT;
        end
        XFER_WAIT:
          if (ack_sync[1] == ack_sync[2] && ack_sync[2] == req_tgl)
            xfer_state <= XFER_IDLE;
        default:
          xfer_state <= XFER_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link domain: settings, frame counter, serial drivers
  // ----------------------------------------------------------------
  logic [2:0]               req_sync;
  bundle_type               live;
  logic                     fsync_prev;
  logic                     frame_edge;
  logic                     half;
  logic [CNT_W-1:0]         bit_cnt;
  logic [5:0]               cur_slot;
  logic                     slot_ok;
  logic [CHANS-1:0]         hit;
  logic [CHANS-1:0]         lane_bit;
  logic [CHANS-1:0]         lane_line;
  logic [CHANS-1:0]         pri_hit;
  logic [CHANS-1:0]         sec_hit;

  // Request toggle: three stages, taken when the last two agree
  always_ff @(posedge BIT_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
      req_sync <= '0;
    else
      req_sync <= {req_sync[1:0], req_tgl};
  end

  // Copy the held bundle; words are stable while the toggle is in flight
  always_ff @(posedge BIT_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ack_tgl <= 1'b0;
      live    <= '{half_mode: 1'b0,
                   cfg: {chan_cfg_type'({LINE_PRIMARY, SLOT8_RESET}),
                         chan_cfg_type'({LINE_PRIMARY, SLOT7_RESET}),
                         chan_cfg_type'({LINE_PRIMARY, SLOT6_RESET})},
                   samples: '0};
    end
    else if (req_sync[1] == req_sync[2] && req_sync[2] != ack_tgl)
    begin
      live    <= bundle;
      ack_tgl <= req_sync[2];
    end
  end

  // Frame edge: rising sync in TDM, either edge in half-frame formats
  assign frame_edge = live.half_mode ? (FRAME_SYNC_I != fsync_prev)
                                     : (FRAME_SYNC_I && !fsync_prev);

  // Bit counter saturates so a late or missing sync stops all driving
  always_ff @(posedge BIT_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fsync_prev <= 1'b0;
      bit_cnt    <= CNT_MAX;
      half       <= 1'b0;
      link_seen  <= 1'b0;
    end
    else
    begin
      fsync_prev <= FRAME_SYNC_I;
      if (frame_edge)
      begin
        bit_cnt   <= '0;
        half      <= !FRAME_SYNC_I;  // Sync high marks the left half
        link_seen <= 1'b1;
      end
      else if (bit_cnt != CNT_MAX)
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Slot position: TDM 0..63, or {right half, slot in half}
  always_comb
  begin
    if (live.half_mode)
    begin
      cur_slot = {half, bit_cnt[BIT_IDX_W+4:BIT_IDX_W]};
      slot_ok  = (bit_cnt < CNT_HALF_END);
    end
    else
    begin
      cur_slot = bit_cnt[BIT_IDX_W+5:BIT_IDX_W];
      slot_ok  = (bit_cnt < CNT_TDM_END);
    end
  end

  // One lane per channel
  genvar g;
  generate
    for (g = 0; g < CHANS; g++)
    begin : g_lane
      slot_lane u_lane
      (
        .cfg_i      (live.cfg[g]),
        .sample_i   (live.samples[g]),
        .cur_slot_i (cur_slot),
        .bit_idx_i  (bit_cnt[BIT_IDX_W-1:0]),
        .slot_ok_i  (slot_ok),
        .hit_o      (hit[g]),
        .bit_o      (lane_bit[g]),
        .line_o     (lane_line[g])
      );
    end
  endgenerate

  assign pri_hit = hit & ~lane_line;
  assign sec_hit = hit & lane_line;

  // Registered drivers; enable only inside an owned slot
  always_ff @(posedge BIT_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      PRIMARY_SERIAL_OUT_O     <= 1'b0;
      PRIMARY_SERIAL_OUT_OE_O  <= 1'b0;
      SECONDARY_OUT_PIN_A_O    <= 1'b0;
      SECONDARY_OUT_PIN_A_OE_O <= 1'b0;
    end
    else
    begin
      PRIMARY_SERIAL_OUT_O     <= |(pri_hit & lane_bit);
      PRIMARY_SERIAL_OUT_OE_O  <= |pri_hit;
      SECONDARY_OUT_PIN_A_O    <= |(sec_hit & lane_bit);
      SECONDARY_OUT_PIN_A_OE_O <= |sec_hit;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ch6_write;
    AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] && bus_idx == IDX_CH6;
  endsequence

  sequence s_read_done;
    AVS_READ_I && !AVS_WAITREQUEST_O;
  endsequence

  a_ch6_reset_val: assert property (@(posedge REF_CLK_I) $rose(rst_n) |->
    cfg[0].slot_index == SLOT6_RESET && cfg[0].line_sel == LINE_PRIMARY)
    else $error("channel six reset value wrong");

  a_ch7_reset_val: assert property (@(posedge REF_CLK_I) $rose(rst_n) |->
    cfg[1].slot_index == SLOT7_RESET && cfg[1].line_sel == LINE_PRIMARY)
    else $error("channel seven reset value wrong");

  a_ch8_reset_val: assert property (@(posedge REF_CLK_I) $rose(rst_n) |->
    cfg[2].slot_index == SLOT8_RESET && cfg[2].line_sel == LINE_PRIMARY)
    else $error("channel eight reset value wrong");

  a_line_sel_write: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    s_ch6_write |=> cfg[0].line_sel == $past(AVS_WRITEDATA_I[LINE_BIT])
                 && cfg[0].slot_index == $past(AVS_WRITEDATA_I[SLOT_MSB:0]))
    else $error("channel six write not stored");

  a_reserved_reads_zero: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    s_read_done |-> AVS_READDATA_O[RSVD_BIT] == RSVD_VALUE)
    else $error("reserved bit read as one");

  a_wait_one_cycle: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    $rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("waitrequest not released after one cycle");

  a_primary_only_hit: assert property (@(posedge BIT_CLK_I) disable iff (!lrst_n)
    PRIMARY_SERIAL_OUT_OE_O |-> $past(slot_ok) && $past(|pri_hit))
    else $error("primary line driven outside an owned slot");

  a_secondary_only_hit: assert property (@(posedge BIT_CLK_I) disable iff (!lrst_n)
    SECONDARY_OUT_PIN_A_OE_O |-> $past(|sec_hit))
    else $error("secondary line driven outside an owned slot");

  a_right_half_slot: assert property (@(posedge BIT_CLK_I) disable iff (!lrst_n)
    (live.half_mode && half && slot_ok) |-> !fsync_prev)
    else $error("right half slot used while sync marks the left half");

  a_frame_restart: assert property (@(posedge BIT_CLK_I) disable iff (!lrst_n)
    frame_edge |=> bit_cnt == '0 ##1 bit_cnt == CNT_W'(1))
    else $error("frame counter did not restart");

endmodule // asi_slot_map

// >>> asi_slot_pkg.sv
/*
  Package for the slot map of audio channels six to eight: register indices, field layout,
  reset values, serial framing constants and the carrier types shared by the design files.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package asi_slot_pkg;

  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam int          IDX_W          = 6;
  localparam int          DATA_W         = 32;
  localparam logic [5:0]  IDX_CH6        = 6'h10;
  localparam logic [5:0]  IDX_CH7        = 6'h11;
  localparam logic [5:0]  IDX_CH8        = 6'h12;
  localparam logic [5:0]  IDX_FORMAT     = 6'h20;
  localparam logic [5:0]  IDX_STATUS     = 6'h21;
  localparam int          IDX_LSB        = 2;

  // ----------------------------------------------------------------
  // Field layout of a channel slot register, the format register and the status register
  // ----------------------------------------------------------------
  localparam int          RSVD_BIT       = 7;
  localparam int          LINE_BIT       = 6;
  localparam int          SLOT_MSB       = 5;
  localparam int          CHANS          = 3;
  localparam logic [5:0]  SLOT6_RESET    = 6'h05;
  localparam logic [5:0]  SLOT7_RESET    = 6'h06;
  localparam logic [5:0]  SLOT8_RESET    = 6'h07;
  localparam logic        LINE_PRIMARY   = 1'b0;
  localparam logic        LINE_SECONDARY = 1'b1;
  localparam logic        RSVD_VALUE     = 1'b0;
  localparam int          FMT_HALF_BIT   = 0;
  localparam int          STS_LINK_BIT   = 0;
  localparam int          STS_BUSY_BIT   = 1;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam int          SLOT_BITS      = 32;
  localparam int          BIT_IDX_W      = 5;
  localparam int          CNT_W          = 12;
  localparam logic [11:0] CNT_TDM_END    = 12'h800;  // 64 slots of 32 bits
  localparam logic [11:0] CNT_HALF_END   = 12'h400;  // 32 slots of 32 bits
  localparam logic [11:0] CNT_MAX        = 12'hfff;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       line_sel;
    logic [5:0] slot_index;
  } chan_cfg_type;

  typedef logic [CHANS-1:0][SLOT_BITS-1:0] sample_set_type;

  typedef struct packed {
    logic                          half_mode;
    chan_cfg_type [CHANS-1:0]      cfg;
    sample_set_type                samples;
  } bundle_type;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_LOAD = 2'b01,
    XFER_WAIT = 2'b11
  } xfer_state_type;

endpackage

// >>> slot_lane.sv
/*
  One channel lane: decides whether the channel owns the current serial slot and which bit
  it puts on its selected line. Purely combinational.
  Assumes the slot position and bit index come from the link-domain frame counter.
*/
`timescale 1ns/1ps
module slot_lane
(
  // Channel settings and sample
  input  wire asi_slot_pkg::chan_cfg_type               cfg_i,
  input  wire logic [asi_slot_pkg::SLOT_BITS-1:0]       sample_i,
  // Frame position
  input  wire logic [5:0]                               cur_slot_i,
  input  wire logic [asi_slot_pkg::BIT_IDX_W-1:0]       bit_idx_i,
  input  wire logic                                     slot_ok_i,
  // Lane result
  output logic                                          hit_o,
  output logic                                          bit_o,
  output logic                                          line_o
);
  import asi_slot_pkg::*;

  // Slot compare: TDM slot n or the half-frame position {half, slot}
  assign hit_o  = slot_ok_i && (cur_slot_i == cfg_i.slot_index);
  // Word goes out most significant bit first
  assign bit_o  = sample_i[(BIT_IDX_W)'(SLOT_BITS - 1) - bit_idx_i];
  assign line_o = cfg_i.line_sel;

endmodule // slot_lane

// >>> host_serial_rx.sv
/*
  Host receiver model: makes bit clock and frame sync for one frame on request and
  records every bit and enable seen on both device lines.
  Assumes the device launches its lines on the rising bit-clock edge.
*/
`timescale 1ns/1ps
module host_serial_rx
(
  // Link clocking
  output logic      bclk_o,
  output logic      fsync_o,
  // Device lines
  input  wire logic pri_i,
  input  wire logic pri_oe_i,
  input  wire logic sec_i,
  input  wire logic sec_oe_i
);
  logic [1:0] dat [0:2047];
  logic [1:0] oen [0:2047];

  // Idle levels at time zero
  initial
  begin
    bclk_o  = 1'b0;
    fsync_o = 1'b0;
  end

  // One frame; the clock stands still between frames, as a gating host would
  // Sampling on the falling edge keeps clear of the launch edge
  task automatic frame(input logic half, input int h);
    int last;
    last = half ? 2 * h : h;
    for (int i = 0; i < 2048; i++)
    begin
      dat[i] = 2'b00;
      oen[i] = 2'b00;
    end
    for (int p = 0; p <= last; p++)
    begin
      fsync_o = half ? (p < h) : (p == 0);
      #62.5;
      bclk_o = 1'b1;
      #62.5;
      bclk_o = 1'b0;
      if (p > 0)
      begin
        dat[p-1] = {sec_i, pri_i};
        oen[p-1] = {sec_oe_i, pri_oe_i};
      end
    end
  endtask
endmodule // host_serial_rx

// >>> asi_slot_map_ch6_to_ch8_bench.sv
/*
  Bench for the slot map of channels six to eight: register access over Avalon-MM and
  frame placement checked through the host receiver model.
  Assumes asi_slot_pkg, asi_slot_map and host_serial_rx are compiled first.
*/
`timescale 1ns/1ps
module asi_slot_map_ch6_to_ch8_bench;
  import asi_slot_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] W6 = 32'ha5c30f81;
  localparam logic [31:0] W7 = 32'h3c96e1d2;
  localparam logic [31:0] W8 = 32'h5a0f7e24;
  logic              ref_clk    = 1'b0;
  logic              resetn     = 1'b0;
  logic [ADDR_W-1:0] avs_addr   = '0;
  logic              avs_rd     = 1'b0;
  logic              avs_wr     = 1'b0;
  logic [DATA_W-1:0] avs_wdata  = '0;
  logic [3:0]        avs_be     = 4'hf;
  logic [DATA_W-1:0] avs_rdata;
  logic              avs_wait;
  sample_set_type    samples    = '0;
  logic              sample_vld = 1'b0;
  logic              bclk, fsync, pri, pri_oe, sec, sec_oe;
  int                errors     = 0;
  int                cmp_count  = 0;

  // System clock, 100 ns
  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  asi_slot_map dut (.REF_CLK_I(ref_clk), .RESETN_I(resetn), .AVS_ADDRESS_I(avs_addr),
    .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wdata),
    .AVS_BYTEENABLE_I(avs_be), .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_wait),
    .SAMPLE_DATA_I(samples), .SAMPLE_VALID_I(sample_vld), .BIT_CLK_I(bclk),
    .FRAME_SYNC_I(fsync), .PRIMARY_SERIAL_OUT_O(pri), .PRIMARY_SERIAL_OUT_OE_O(pri_oe),
    .SECONDARY_OUT_PIN_A_O(sec), .SECONDARY_OUT_PIN_A_OE_O(sec_oe));

  host_serial_rx host (.bclk_o(bclk), .fsync_o(fsync), .pri_i(pri), .pri_oe_i(pri_oe),
    .sec_i(sec), .sec_oe_i(sec_oe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic done;
    int   n;
    done = 1'b0;
    n    = 0;
    q    = '0;
    @(posedge ref_clk);
    avs_addr  <= a;
    avs_wdata <= d;
    avs_wr    <= wr;
    avs_rd    <= ~wr;
    // Waitrequest and read data are taken at the rising edge itself
    while (!done && n < 100)
    begin
      @(posedge ref_clk);
      done = (avs_wait === 1'b0);
      q    = avs_rdata;
      n++;
    end
    chk({31'h0, done}, 32'h1);
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(q, exp);
  endtask

  // First frame lets settings and samples cross; the second is judged
  task automatic frames(input logic half, input int h);
    host.frame(half, h);
    host.frame(half, h);
  endtask

  // A whole word, MSB first, with the enable up through all 32 bits
  task automatic slot_chk(input int ln, input int first, input logic [31:0] w);
    logic [31:0] got;
    logic [31:0] en;
    for (int i = 0; i < 32; i++)
    begin
      got[31-i] = host.dat[first+i][ln];
      en[31-i]  = host.oen[first+i][ln];
    end
    chk(en, 32'hffffffff);
    chk(got, w);
  endtask

  // Enabled bits over the frame; catches driving outside the slot
  task automatic cnt_chk(input int ln, input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 2048; i++)
      n += int'(host.oen[i][ln] === 1'b1);
    chk(32'(n), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(8'h40, 32'h05);
    rd_chk(8'h44, 32'h06);
    rd_chk(8'h48, 32'h07);
    rd_chk(8'h4c, 32'h00);
    rd_chk(8'h84, 32'h02); // No frame seen yet, transfer waits for the bit clock
  endtask

  // Reserved bit reads zero; a write without the low byte enable is ignored
  task automatic t_rsvd;
    wr_reg(8'h40, 32'h7f);
    rd_chk(8'h40, 32'h7f);
    wr_reg(8'h40, 32'h05);
    avs_be <= 4'he;
    wr_reg(8'h48, 32'h20);
    avs_be <= 4'hf;
    rd_chk(8'h48, 32'h07);
  endtask

  // Reset placement: three adjacent TDM slots on the primary line
  task automatic t_tdm_default;
    @(posedge ref_clk);
    samples    <= {W8, W7, W6};
    sample_vld <= 1'b1;
    @(posedge ref_clk);
    sample_vld <= 1'b0;
    frames(1'b0, 320);
    slot_chk(0, 160, W6);
    slot_chk(0, 192, W7);
    slot_chk(0, 224, W8);
    cnt_chk(0, 96);
    cnt_chk(1, 0);
  endtask

  // Secondary line, upper TDM slot and slot zero
  task automatic t_line;
    wr_reg(8'h44, 32'h61);
    rd_chk(8'h44, 32'h61);
    wr_reg(8'h48, 32'h00);
    frames(1'b0, 1100);
    slot_chk(0, 0, W8);
    slot_chk(0, 160, W6);
    slot_chk(1, 1056, W7);
    cnt_chk(0, 64);
    cnt_chk(1, 32);
  endtask

  // Half-frame mode: left 31, right 0 and right 31
  task automatic t_half;
    wr_reg(8'h80, 32'h01);
    rd_chk(8'h80, 32'h01);
    wr_reg(8'h40, 32'h3f);
    wr_reg(8'h44, 32'h60);
    wr_reg(8'h48, 32'h1f);
    frames(1'b1, 1024);
    slot_chk(0, 992, W8);
    slot_chk(1, 1024, W7);
    slot_chk(0, 2016, W6);
    cnt_chk(0, 64);
    cnt_chk(1, 32);
    rd_chk(8'h84, 32'h01); // Frame seen, transfer settled
  endtask

  // ----------------------------------------------------------------
  // Verdict and sequence
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bit clock runs during reset so the link side is cleared too
  initial
  begin
    fork
      host.frame(1'b0, 2);
      repeat (4) @(posedge ref_clk);
    join
    @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_rsvd;
    t_tdm_default;
    t_line;
    t_half;
    finish_test;
  end

  // Watchdog, well beyond the expected run of about 1 ms
  initial
  begin
    #3000000;
    errors++;
    finish_test;
  end
endmodule // asi_slot_map_ch6_to_ch8_bench
